// >>> vac_defs.svh
// Constants for the VLIW architectural state block.
`ifndef VAC_DEFS_SVH
`define VAC_DEFS_SVH

// ****************************************
// Control/status word fields
// ****************************************
`define VAC_CSW_RESET       32'h0000_0800
`define VAC_CSW_RM_LO       0
`define VAC_CSW_RM_HI       1
`define VAC_CSW_IEN         2
`define VAC_CSW_BSX         3
`define VAC_CSW_FLAG_LO     4
`define VAC_CSW_FLAG_HI     10
`define VAC_CSW_CS          11
`define VAC_CSW_TRAP_LO     12
`define VAC_CSW_TRAP_HI     18
`define VAC_CSW_MSE         19
`define VAC_CSW_MISALIGNED_STORE_TRAP_EN      20
`define VAC_CSW_WBE         21
`define VAC_CSW_WRITEBACK_OVERFLOW_TRAP_EN      22
`define VAC_CSW_TFE         23
`define VAC_CSW_WR_MASK     32'h00FF_FFFF

// ****************************************
// Fixed values and timing
// ****************************************
`define VAC_ZERO_VALUE      32'h0000_0000
`define VAC_ONE_VALUE       32'h0000_0001
`define VAC_PC_RESET        32'h0000_0000
`define VAC_INSTR_BYTES     32'h0000_0020
`define VAC_BRANCH_DELAY    2'h3
`define VAC_WB_LIMIT        5

`endif

// >>> vac_pkg.sv
// Types shared by the VLIW architectural state block.
package vac_pkg;

	typedef enum logic [2:0] {
		VAC_OP_NOP  = 3'h0,
		VAC_OP_IADD = 3'h1,
		VAC_OP_LD32 = 3'h2,
		VAC_OP_ST8  = 3'h3,
		VAC_OP_ST16 = 3'h4,
		VAC_OP_ST32 = 3'h5,
		VAC_OP_JMPI = 3'h6,
		VAC_OP_JMPU = 3'h7
	} vac_op_t;

	typedef enum logic [1:0] {
		VAC_SZ_BYTE = 2'h0,
		VAC_SZ_HALF = 2'h1,
		VAC_SZ_WORD = 2'h2
	} vac_size_t;

endpackage

// >>> vac_arch_state.sv
// Register file, issue, control/status word, branch latches and cycle tally of the VLIW core.
// What this block does
// - 128 registers of 32 bits each.
// - Index zero always reads zero.
// - Index one always reads one.
// - One instruction of five operations per cycle.
// - Operation acts only when guard true.
// - Add result usable next cycle.
// - Word load result usable three cycles later.
// - Taken branch has three delay slots.
// - At most two memory operations per instruction.
// - Over five write-backs set overflow flag.
// - Control/status word resets to 0x800.
// - Floating flags sticky, cleared by software write.
// - Flags AND trap enables request exception.
// - Rounding field drives floating rounding.
// - Byte order bit steers memory data.
// - Interrupt gate masks all but NMI.
// - Cycle count all or non-stall cycles.
// - Misaligned store sets flag, trap if enabled.
// - Unaligned address bits forced to zero.
// - Branch latches capture interrupted/uninterrupted targets.
// - First-exit bit traps next interruptible jump.
// - Hardware-updated bits beat software write.
// - Guard truth is least significant bit.
// - Tally copy refreshed on uninterrupted interruptible jumps.
`include "vac_defs.svh"

module vac_arch_state #(
	parameter int NSLOT = 5,
	parameter int NREG  = 128,
	parameter int NMEM  = 2
) (
	// Clock and reset.
	input  wire logic             clock_i,
	input  wire logic             rst_b_i,
	// Instruction issue, one entry per operation slot.
	input  wire logic             stall_i,
	input  wire vac_pkg::vac_op_t op_kind_i  [NSLOT],
	input  wire logic [6:0]       guard_idx_i [NSLOT],
	input  wire logic [6:0]       src1_idx_i [NSLOT],
	input  wire logic [6:0]       src2_idx_i [NSLOT],
	input  wire logic [6:0]       dest_idx_i [NSLOT],
	input  wire logic [31:0]      disp_i     [NSLOT],
	// Data memory ports.
	output logic                  mem_req_o   [NMEM],
	output logic                  mem_we_o    [NMEM],
	output logic [31:0]           mem_addr_o  [NMEM],
	output logic [1:0]            mem_size_o  [NMEM],
	output logic [31:0]           mem_wdata_o [NMEM],
	input  wire logic [31:0]      mem_rdata_i [NMEM],
	// Event sources.
	input  wire logic [6:0]       fp_flags_i,
	input  wire logic             irq_i,
	input  wire logic             nmi_i,
	// Software access to special registers.
	input  wire logic             csw_wr_i,
	input  wire logic [31:0]      csw_wdata_i,
	input  wire logic             ibt_wr_i,
	input  wire logic             ubt_wr_i,
	input  wire logic [31:0]      bt_wdata_i,
	// State and requests.
	output logic [31:0]           control_status_word_o,
	output logic [31:0]           interrupted_branch_target_o,
	output logic [31:0]           uninterrupted_branch_target_o,
	output logic [63:0]           cycle_tally_o,
	output logic [31:0]           cycle_master_lo_o,
	output logic [31:0]           instruction_pointer_o,
	output logic [1:0]            rounding_mode_o,
	output logic                  byte_order_select_o,
	output logic                  int_take_o,
	output logic                  exc_req_o,
	output logic                  jump_done_o
);

	// ****************************************
	// Register file
	// ****************************************
	logic [31:0] regs [NREG];

	function automatic logic [31:0] rd_reg(input logic [6:0] idx);
		if (idx == 7'h00) begin
			return `VAC_ZERO_VALUE;
		end else if (idx == 7'h01) begin
			return `VAC_ONE_VALUE;
		end
		return regs[idx];
	endfunction

	function automatic logic [31:0] swap_bytes(input logic [31:0] w, input logic big);
		return big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	endfunction

	logic [31:0] csw_q;
	logic [31:0] csw_d;
	logic [31:0] pc_q;
	logic [31:0] ibt_q;
	logic [31:0] ubt_q;
	logic [63:0] master_q;
	logic [63:0] tally_q;
	logic [1:0]  br_cnt_q;
	logic [31:0] br_tgt_q;
	logic        br_intr_q;
	logic        ld_v1_q [NMEM];
	logic        ld_v2_q [NMEM];
	logic [6:0]  ld_d1_q [NMEM];
	logic [6:0]  ld_d2_q [NMEM];

	// ****************************************
	// Issue decode
	// ****************************************
	logic        exec      [NSLOT];
	logic [31:0] sum       [NSLOT];
	logic        mis_store;
	logic        br_take;
	logic [31:0] br_tgt;
	logic        br_ijmp;
	logic        m_req     [NMEM];
	logic        m_we      [NMEM];
	logic [31:0] m_addr    [NMEM];
	logic [1:0]  m_size    [NMEM];
	logic [31:0] m_wdata   [NMEM];
	logic [6:0]  m_dst     [NMEM];
	logic [3:0]  wb_cnt;
	logic        transfer;
	logic        jump_intr;

	always_comb begin
		int          p;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] g;
		logic        st;
		logic [1:0]  sz;
		p = 0;
		a = '0;
		b = '0;
		g = '0;
		st = 1'b0;
		sz = 2'h0;
		mis_store = 1'b0;
		br_take = 1'b0;
		br_tgt = '0;
		br_ijmp = 1'b0;
		wb_cnt = 4'h0;
		for (int m = 0; m < NMEM; m++) begin
			m_req[m] = 1'b0;
			m_we[m] = 1'b0;
			m_addr[m] = '0;
			m_size[m] = 2'h0;
			m_wdata[m] = '0;
			m_dst[m] = '0;
			if (ld_v2_q[m]) begin
				wb_cnt = wb_cnt + 4'h1;
			end
		end
		for (int s = 0; s < NSLOT; s++) begin
			a = rd_reg(src1_idx_i[s]);
			b = rd_reg(src2_idx_i[s]);
			g = rd_reg(guard_idx_i[s]);
			exec[s] = (op_kind_i[s] != vac_pkg::VAC_OP_NOP) && !stall_i
				&& g[0];
			sum[s] = a + disp_i[s];
			if (op_kind_i[s] == vac_pkg::VAC_OP_IADD) begin
				sum[s] = a + b;
				if (exec[s]) begin
					wb_cnt = wb_cnt + 4'h1;
				end
			end
			st = (op_kind_i[s] == vac_pkg::VAC_OP_ST8) || (op_kind_i[s] == vac_pkg::VAC_OP_ST16)
				|| (op_kind_i[s] == vac_pkg::VAC_OP_ST32);
			sz = (op_kind_i[s] == vac_pkg::VAC_OP_ST8) ? 2'(vac_pkg::VAC_SZ_BYTE) :
				(op_kind_i[s] == vac_pkg::VAC_OP_ST16) ? 2'(vac_pkg::VAC_SZ_HALF) :
				2'(vac_pkg::VAC_SZ_WORD);
			// Slots beyond the second memory operation are never issued by the scheduler.
			if (exec[s] && (st || op_kind_i[s] == vac_pkg::VAC_OP_LD32) && p < NMEM) begin
				m_req[p] = 1'b1;
				m_we[p] = st;
				m_size[p] = sz;
				m_dst[p] = dest_idx_i[s];
				m_wdata[p] = swap_bytes(b, csw_q[`VAC_CSW_BSX]);
				m_addr[p] = sum[s];
				if (sz == 2'(vac_pkg::VAC_SZ_HALF)) begin
					m_addr[p][0] = 1'b0;
				end else if (sz == 2'(vac_pkg::VAC_SZ_WORD)) begin
					m_addr[p][1:0] = 2'h0;
				end
				if (st && ((sz == 2'(vac_pkg::VAC_SZ_HALF) && sum[s][0])
					|| (sz == 2'(vac_pkg::VAC_SZ_WORD) && sum[s][1:0] != 2'h0))) begin
					mis_store = 1'b1;
				end
				p = p + 1;
			end
			if (exec[s] && (op_kind_i[s] == vac_pkg::VAC_OP_JMPI
				|| op_kind_i[s] == vac_pkg::VAC_OP_JMPU) && a[0]) begin
				br_take = 1'b1;
				br_tgt = b;
				br_ijmp = (op_kind_i[s] == vac_pkg::VAC_OP_JMPI);
			end
		end
	end

	// ****************************************
	// Register write-back
	// ****************************************
	always_ff @(posedge clock_i) begin
		for (int s = 0; s < NSLOT; s++) begin
			if (exec[s] && op_kind_i[s] == vac_pkg::VAC_OP_IADD && dest_idx_i[s] > 7'h01) begin
				regs[dest_idx_i[s]] <= sum[s];
			end
		end
		for (int m = 0; m < NMEM; m++) begin
			if (ld_v2_q[m] && ld_d2_q[m] > 7'h01) begin
				regs[ld_d2_q[m]] <= swap_bytes(mem_rdata_i[m], csw_q[`VAC_CSW_BSX]);
			end
		end
	end

	// ****************************************
	// Memory request and load return pipeline
	// ****************************************
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int m = 0; m < NMEM; m++) begin
				mem_req_o[m] <= 1'b0;
				mem_we_o[m] <= 1'b0;
				mem_addr_o[m] <= '0;
				mem_size_o[m] <= 2'h0;
				mem_wdata_o[m] <= '0;
				ld_v1_q[m] <= 1'b0;
				ld_v2_q[m] <= 1'b0;
				ld_d1_q[m] <= '0;
				ld_d2_q[m] <= '0;
			end
		end else begin
			for (int m = 0; m < NMEM; m++) begin
				mem_req_o[m] <= m_req[m];
				mem_we_o[m] <= m_we[m];
				mem_addr_o[m] <= m_addr[m];
				mem_size_o[m] <= m_size[m];
				mem_wdata_o[m] <= m_wdata[m];
				ld_v1_q[m] <= m_req[m] && !m_we[m];
				ld_d1_q[m] <= m_dst[m];
				ld_v2_q[m] <= ld_v1_q[m];
				ld_d2_q[m] <= ld_d1_q[m];
			end
		end
	end

	// ****************************************
	// Branch delay slots and program counter
	// ****************************************
	assign transfer = (br_cnt_q == 2'h1) && !stall_i;
	assign int_take_o = nmi_i || (irq_i && csw_q[`VAC_CSW_IEN]);
	assign jump_intr = br_intr_q && (int_take_o || exc_req_o);

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pc_q <= `VAC_PC_RESET;
			br_cnt_q <= 2'h0;
			br_tgt_q <= '0;
			br_intr_q <= 1'b0;
		end else if (!stall_i) begin
			pc_q <= transfer ? br_tgt_q : pc_q + `VAC_INSTR_BYTES;
			if (br_take && br_cnt_q == 2'h0) begin
				br_cnt_q <= `VAC_BRANCH_DELAY;
				br_tgt_q <= br_tgt;
				br_intr_q <= br_ijmp;
			end else if (br_cnt_q != 2'h0) begin
				br_cnt_q <= br_cnt_q - 2'h1;
			end
		end
	end

	// ****************************************
	// Branch target latches
	// ****************************************
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ibt_q <= '0;
			ubt_q <= '0;
		end else begin
			if (ibt_wr_i) begin
				ibt_q <= bt_wdata_i;
			end else if (transfer && br_intr_q) begin
				ibt_q <= br_tgt_q;
			end
			if (ubt_wr_i) begin
				ubt_q <= bt_wdata_i;
			end else if (transfer && br_intr_q && !jump_intr) begin
				ubt_q <= br_tgt_q;
			end
		end
	end

	// ****************************************
	// Cycle tally
	// ****************************************
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			master_q <= '0;
			tally_q <= '0;
		end else begin
			if (csw_q[`VAC_CSW_CS] || !stall_i) begin
				master_q <= master_q + 64'h1;
			end
			if (transfer && br_intr_q && !jump_intr) begin
				tally_q <= master_q;
			end
		end
	end

	// ****************************************
	// Control/status word
	// ****************************************
	always_comb begin
		csw_d = csw_q;
		if (csw_wr_i) begin
			csw_d = (csw_q & ~`VAC_CSW_WR_MASK) | (csw_wdata_i & `VAC_CSW_WR_MASK);
		end
		csw_d[`VAC_CSW_FLAG_HI:`VAC_CSW_FLAG_LO] =
			csw_d[`VAC_CSW_FLAG_HI:`VAC_CSW_FLAG_LO] | fp_flags_i;
		if (mis_store) begin
			csw_d[`VAC_CSW_MSE] = 1'b1;
		end
		if (wb_cnt > 4'(`VAC_WB_LIMIT)) begin
			csw_d[`VAC_CSW_WBE] = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			csw_q <= `VAC_CSW_RESET;
		end else begin
			csw_q <= csw_d;
		end
	end

	// ****************************************
	// Exception request and outputs
	// ****************************************
	always_comb begin
		exc_req_o = (|(csw_q[`VAC_CSW_FLAG_HI:`VAC_CSW_FLAG_LO]
			& csw_q[`VAC_CSW_TRAP_HI:`VAC_CSW_TRAP_LO]))
			|| (csw_q[`VAC_CSW_MSE] && csw_q[`VAC_CSW_MISALIGNED_STORE_TRAP_EN])
			|| (csw_q[`VAC_CSW_WBE] && csw_q[`VAC_CSW_WRITEBACK_OVERFLOW_TRAP_EN])
			|| (transfer && br_intr_q && csw_q[`VAC_CSW_TFE]);
	end

	assign jump_done_o = transfer && br_intr_q && !jump_intr;
	assign control_status_word_o = csw_q;
	assign interrupted_branch_target_o = ibt_q;
	assign uninterrupted_branch_target_o = ubt_q;
	assign cycle_tally_o = tally_q;
	assign cycle_master_lo_o = master_q[31:0];
	assign instruction_pointer_o = pc_q;
	assign rounding_mode_o = csw_q[`VAC_CSW_RM_HI:`VAC_CSW_RM_LO];
	assign byte_order_select_o = csw_q[`VAC_CSW_BSX];

endmodule

// >>> vac_arch_state_props.sv
// Port assertions for the VLIW architectural state block.
module vac_arch_state_props #(
	parameter int NMEM = 2
) (
	// Clock, reset and inputs.
	input wire logic        clock_i,
	input wire logic        rst_b_i,
	input wire logic        stall_i,
	input wire logic [6:0]  fp_flags_i,
	input wire logic        irq_i,
	input wire logic        nmi_i,
	input wire logic        csw_wr_i,
	input wire logic [31:0] csw_wdata_i,
	input wire logic        ibt_wr_i,
	input wire logic        ubt_wr_i,
	// Outputs under watch.
	input wire logic        mem_req_o [NMEM],
	input wire logic [31:0] mem_addr_o [NMEM],
	input wire logic [1:0]  mem_size_o [NMEM],
	input wire logic [31:0] control_status_word_o,
	input wire logic [31:0] interrupted_branch_target_o,
	input wire logic [31:0] uninterrupted_branch_target_o,
	input wire logic [63:0] cycle_tally_o,
	input wire logic [31:0] cycle_master_lo_o,
	input wire logic        int_take_o,
	input wire logic        exc_req_o,
	input wire logic        jump_done_o
);
	// ********************************
	// Checks
	// ********************************
	logic [31:0] w;
	assign w = control_status_word_o;
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	chk_csw_reset: assert property (
		$rose(rst_b_i) |-> w == 32'h800) else $error("Control word reset value wrong.");
	chk_int_gate: assert property (
		irq_i | nmi_i |-> int_take_o == (nmi_i | w[2])) else $error("Interrupt gating wrong.");
	chk_fp_trap: assert property (
		|(w[10:4] & w[18:12]) |-> exc_req_o) else $error("Missing float exception.");
	chk_err_trap: assert property (
		(w[19] & w[20]) | (w[21] & w[22]) |-> exc_req_o) else $error("Missing error exception.");
	chk_flag_set: assert property (
		|fp_flags_i |=> (w[10:4] & $past(fp_flags_i)) == $past(fp_flags_i))
		else $error("Float flag not set.");
	chk_flag_sticky: assert property (
		!csw_wr_i |=> (w[10:4] & $past(w[10:4])) == $past(w[10:4]))
		else $error("Float flag lost.");
	chk_sw_fields: assert property (
		csw_wr_i |=> (w & 32'h00D7_F80F) == ($past(csw_wdata_i) & 32'h00D7_F80F))
		else $error("Written field lost.");
	chk_exit_hold: assert property (
		!csw_wr_i |=> $stable(w[23])) else $error("First exit bit changed by hardware.");
	chk_count_all: assert property (
		w[11] |=> cycle_master_lo_o == $past(cycle_master_lo_o) + 32'h1)
		else $error("Cycle count missed.");
	chk_stall_hold: assert property (
		!w[11] && stall_i |=> $stable(cycle_master_lo_o)) else $error("Stall cycle counted.");
	chk_tally_hold: assert property (
		!jump_done_o |=> $stable(cycle_tally_o)) else $error("Tally copy changed.");
	chk_jump_clean: assert property (
		jump_done_o && !ibt_wr_i && !ubt_wr_i
		|=> uninterrupted_branch_target_o == interrupted_branch_target_o)
		else $error("Uninterrupted target not latched.");
	chk_tally_copy: assert property (
		jump_done_o |=> cycle_tally_o[31:0] == $past(cycle_master_lo_o))
		else $error("Tally copy wrong.");
	chk_addr_align: assert property (
		mem_req_o[0] && mem_size_o[0] == 2'h2 |-> mem_addr_o[0][1:0] == 2'h0)
		else $error("Word address unaligned.");
endmodule

bind vac_arch_state vac_arch_state_props #(.NMEM(NMEM)) u_props (
	.clock_i, .rst_b_i, .stall_i, .fp_flags_i, .irq_i, .nmi_i, .csw_wr_i, .csw_wdata_i,
	.ibt_wr_i, .ubt_wr_i, .interrupted_branch_target_o, .uninterrupted_branch_target_o,
	.mem_req_o, .mem_addr_o, .mem_size_o, .control_status_word_o, .cycle_tally_o,
	.cycle_master_lo_o, .int_take_o, .exc_req_o, .jump_done_o
);

// >>> vac_arch_state_tb.sv
// Self-checking testbench for the VLIW architectural state block.
module vac_arch_state_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ********************************
	// Signals and helpers
	// ********************************
	logic             clock_i, rst_b_i, stall_i, irq_i, nmi_i, csw_wr_i;
	logic [6:0]       fp_flags_i;
	logic [31:0]      csw_wdata_i, csw, ibt, ubt, master, ip, a, v, ie;
	vac_pkg::vac_op_t op_kind_i [5];
	logic [6:0]       guard_idx_i [5], src1_idx_i [5], src2_idx_i [5], dest_idx_i [5];
	logic [31:0]      disp_i [5], mem_rdata_i [2], mem_addr_o [2], mem_wdata_o [2];
	logic             mem_req_o [2], mem_we_o [2], bso, take, exc, jdone;
	logic [1:0]       mem_size_o [2], rm;
	logic [63:0]      tally, t;
	logic [15:0]      lfsr;
	int               err_total, total_checks;

	vac_arch_state dut (
		.clock_i, .rst_b_i, .stall_i, .op_kind_i, .guard_idx_i, .src1_idx_i, .src2_idx_i,
		.dest_idx_i, .disp_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_size_o, .mem_wdata_o,
		.mem_rdata_i, .fp_flags_i, .irq_i, .nmi_i, .csw_wr_i, .csw_wdata_i, .ibt_wr_i(1'h0),
		.ubt_wr_i(1'h0), .bt_wdata_i(32'h0), .control_status_word_o(csw),
		.interrupted_branch_target_o(ibt), .uninterrupted_branch_target_o(ubt),
		.cycle_tally_o(tally), .cycle_master_lo_o(master), .instruction_pointer_o(ip),
		.rounding_mode_o(rm), .byte_order_select_o(bso), .int_take_o(take), .exc_req_o(exc),
		.jump_done_o(jdone)
	);

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic draw(output logic [31:0] x);
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		x[15:0] = lfsr;
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		x[31:16] = lfsr;
	endtask

	function automatic logic [31:0] guarded_inc(input logic [31:0] x);
		return x[0] ? x + 32'h1 : x;
	endfunction

	task automatic put(input int s, input vac_pkg::vac_op_t k, input logic [6:0] g, p, q, d,
			input logic [31:0] x);
		op_kind_i[s] = k;
		guard_idx_i[s] = g;
		src1_idx_i[s] = p;
		src2_idx_i[s] = q;
		dest_idx_i[s] = d;
		disp_i[s] = x;
	endtask

	task automatic issue();
		@(negedge clock_i);
		for (int s = 0; s < 5; s++) put(s, vac_pkg::VAC_OP_NOP, 7'h01, 7'h0, 7'h0, 7'h0, 32'h0);
	endtask

	task automatic ld(input logic [6:0] d, input logic [31:0] x);
		mem_rdata_i[0] = x;
		put(0, vac_pkg::VAC_OP_LD32, 7'h01, 7'h0, 7'h0, d, 32'h40);
		issue();
		check({mem_req_o[0], mem_we_o[0], mem_addr_o[0]}, {2'h2, 32'h40});
		repeat (2) @(negedge clock_i);
		mem_rdata_i[0] = ~x;
	endtask

	task automatic rd(input logic [6:0] r, output logic [31:0] y);
		put(0, vac_pkg::VAC_OP_ST32, 7'h01, 7'h0, r, 7'h0, 32'h100);
		issue();
		check({mem_req_o[0], mem_we_o[0], mem_size_o[0]}, {2'h3, 2'h2});
		y = mem_wdata_o[0];
	endtask

	task automatic wcsw(input logic [31:0] x);
		@(negedge clock_i);
		csw_wr_i = 1'h1;
		csw_wdata_i = x;
		@(negedge clock_i);
		csw_wr_i = 1'h0;
	endtask

	initial begin
		clock_i = 1'h0;
		forever #25 clock_i = ~clock_i;
	end

	initial begin
		repeat (3000) @(posedge clock_i);
		err_total++;
		complete_run();
	end

	// ********************************
	// Tests
	// ********************************
	initial begin
		lfsr = 16'h6FA4;
		{rst_b_i, stall_i, irq_i, nmi_i, csw_wr_i, fp_flags_i} = 12'h0;
		csw_wdata_i = 32'h0;
		mem_rdata_i = '{32'h5A5A_A5A5, 32'hA5A5_5A5A};
		issue();
		repeat (11) @(negedge clock_i);
		rst_b_i = 1'h1;
		check({csw, tally[31:0]}, {32'h800, 32'h0});
		put(0, vac_pkg::VAC_OP_IADD, 7'h01, 7'h01, 7'h01, 7'h00, 32'h0);
		put(1, vac_pkg::VAC_OP_IADD, 7'h01, 7'h01, 7'h01, 7'h01, 32'h0);
		issue();
		rd(7'h00, v);
		check(v, 32'h0);
		rd(7'h01, v);
		check(v, 32'h1);
		$display("constant registers done");
		for (int i = 0; i < 8; i++) begin
			draw(a);
			if (i == 0) a = 32'hFFFF_FFFF;
			ld(7'h02, a);
			put(0, vac_pkg::VAC_OP_IADD, 7'h02, 7'h02, 7'h01, 7'h02, 32'h0);
			put(1, vac_pkg::VAC_OP_ST32, 7'h01, 7'h00, 7'h02, 7'h00, 32'h100);
			issue();
			check(mem_wdata_o[0], a);
			rd(7'h02, v);
			a = guarded_inc(a);
			check(v, a);
		end
		wcsw(32'h808);
		rd(7'h02, v);
		check({bso, v}, {1'h1, a[7:0], a[15:8], a[23:16], a[31:24]});
		wcsw(32'h800);
		$display("loads and adds done");
		put(0, vac_pkg::VAC_OP_ST16, 7'h01, 7'h00, 7'h02, 7'h00, 32'h103);
		put(1, vac_pkg::VAC_OP_ST32, 7'h01, 7'h00, 7'h02, 7'h00, 32'h206);
		issue();
		check({mem_addr_o[0], mem_size_o[0], mem_addr_o[1]}, {32'h102, 2'h1, 32'h204});
		check({mem_req_o[1], mem_we_o[1], mem_size_o[1], mem_wdata_o[1]}, {2'h3, 2'h2, a});
		check({csw[19], exc}, 2'h2);
		wcsw(32'h0018_0800);
		check(exc, 1'h1);
		wcsw(32'h800);
		check({csw, exc}, {32'h800, 1'h0});
		for (int c = 0; c < 8; c++) begin
			wcsw({20'h0, 4'h8, 5'h0, c[2], c[1:0]});
			irq_i = c[0];
			nmi_i = c[1];
			#1;
			check({take, rm}, {c[1] | c[0] & c[2], c[1:0]});
		end
		@(negedge clock_i);
		{irq_i, nmi_i} = 2'h0;
		$display("stores and modes done");
		draw(a);
		v[6:0] = a[6:0] | 7'h01;
		fp_flags_i = v[6:0];
		wcsw(32'h800);
		fp_flags_i = 7'h0;
		check(csw[10:4], v[6:0]);
		@(negedge clock_i);
		check({csw[10:4], exc}, {v[6:0], 1'h0});
		wcsw({13'h0, ~v[6:0], 1'h1, v[6:0], 4'h0});
		check(exc, 1'h0);
		wcsw({13'h0, v[6:0], 1'h1, v[6:0], 4'h0});
		check(exc, 1'h1);
		wcsw(32'h800);
		check({csw, exc}, {32'h800, 1'h0});
		mem_rdata_i = '{a, ~a};
		for (int n = 0; n < 6; n++) begin
			for (int s = 0; s < 5; s++) begin
				put(s, vac_pkg::VAC_OP_IADD, 7'h01, 7'h01, 7'h01, 7'h10 + 7'(s), 32'h0);
			end
			if (n == 2) begin
				put(0, vac_pkg::VAC_OP_LD32, 7'h01, 7'h00, 7'h00, 7'h20, 32'h40);
				put(1, vac_pkg::VAC_OP_LD32, 7'h01, 7'h00, 7'h00, 7'h21, 32'h44);
			end
			issue();
			if (n == 1 || n == 5) check(csw[21], n == 5);
		end
		wcsw(32'h0060_0800);
		check(exc, 1'h1);
		wcsw(32'h800);
		$display("flags done");
		for (int j = 0; j < 4; j++) begin
			draw(a);
			a[4:0] = 5'h0;
			wcsw({8'h0, 1'(j == 2), 11'h0, 1'h1, 8'h0, 1'(j == 1), 2'h0});
			ld(7'h03, a);
			irq_i = (j == 1);
			t = tally;
			put(0, (j == 3) ? vac_pkg::VAC_OP_JMPU : vac_pkg::VAC_OP_JMPI, 7'h01, 7'h01, 7'h03,
				7'h00, 32'h0);
			issue();
			for (int k = 1; k < 4; k++) begin
				check(jdone, k == 3 && j == 0);
				check(exc, k == 3 && j == 2);
				@(negedge clock_i);
			end
			irq_i = 1'h0;
			if (j == 0) v = a;
			if (j != 3) ie = a;
			check({ip, ibt, ubt}, {a, ie, v});
			check(tally == t, j != 0);
		end
		for (int c = 0; c < 2; c++) begin
			wcsw({20'h0, c[0], 11'h0});
			stall_i = 1'h1;
			a = master;
			repeat (4) @(negedge clock_i);
			check(master, a + (c == 1 ? 32'h4 : 32'h0));
			stall_i = 1'h0;
		end
		$display("jumps and counts done");
		complete_run();
	end
endmodule
